// ### verilog/clock_ctrl_pkg.sv
// Constants, types and register map of the clock source and start-up controller
package clock_ctrl_pkg;

    // APB register map, byte addresses of aligned 32-bit words
    localparam int unsigned  ADDR_W       = 12;
    localparam logic [11:0]  CTRL_OFS     = 12'h000;
    localparam logic [11:0]  STATUS_OFS   = 12'h004;
    localparam logic [11:0]  FUSE_OFS     = 12'h008;
    localparam logic [11:0]  DOMAIN_OFS   = 12'h00C;

    // Control register fields
    localparam int unsigned  CTRL_SLEEP_BIT = 0;
    localparam int unsigned  CTRL_MODE_LSB  = 1;
    localparam int unsigned  CTRL_MODE_MSB  = 2;
    localparam int unsigned  CTRL_ASY_BIT   = 3;

    // Status register fields
    localparam int unsigned  STAT_SRC_LSB   = 0;
    localparam int unsigned  STAT_STATE_LSB = 4;
    localparam int unsigned  STAT_RUN_BIT   = 8;

    // Fuse image; an unprogrammed fuse reads one
    typedef struct packed {
        logic [3:0] clock_source_select;
        logic [1:0] startup_time_select;
        logic       divide_by_eight_fuse;
    } fuse_t;

    localparam int unsigned  FUSE_W       = 7;
    localparam fuse_t        FUSE_DEFAULT = '{clock_source_select:  4'h2,
                                              startup_time_select:  2'h2,
                                              divide_by_eight_fuse: 1'h0};

    // Source-select codes with a single meaning
    localparam logic [3:0]   CODE_EXT     = 4'h0;
    localparam logic [3:0]   CODE_RSV     = 4'h1;
    localparam logic [3:0]   CODE_RC_CAL  = 4'h2;
    localparam logic [3:0]   CODE_RC_128K = 4'h3;
    localparam logic [1:0]   GRP_FS_XTAL  = 2'h3;
    localparam logic [1:0]   GRP_LF_XTAL  = 2'h2;
    localparam logic         FUSE_PROGRAMMED = 1'h0;

    typedef enum logic [2:0] {
        SRC_EXT     = 3'b000,
        SRC_RSV     = 3'b001,
        SRC_RC_CAL  = 3'b010,
        SRC_RC_128K = 3'b011,
        SRC_LF_XTAL = 3'b100,
        SRC_FS_XTAL = 3'b101,
        SRC_LP_XTAL = 3'b110
    } src_t;

    typedef enum logic [2:0] {
        ST_HOLD    = 3'b000,
        ST_DECODE  = 3'b001,
        ST_TIMEOUT = 3'b010,
        ST_STARTUP = 3'b011,
        ST_RUN     = 3'b100,
        ST_SLEEP   = 3'b101,
        ST_WAKE    = 3'b110
    } state_t;

    typedef enum logic [1:0] {
        SLP_IDLE     = 2'b00,
        SLP_ADC_NR   = 2'b01,
        SLP_PWR_DOWN = 2'b10,
        SLP_PWR_SAVE = 2'b11
    } sleep_t;

    // Clock domain enables
    typedef struct packed {
        logic core_clock;
        logic peripheral_clock;
        logic flash_clock;
        logic async_timer_clock;
        logic converter_clock;
    } gate_t;

    // Delay counts, in watchdog or source oscillator cycles
    localparam int unsigned  CNT_W        = 16;
    localparam logic [15:0]  CNT_ZERO     = 16'h0000;
    localparam logic [15:0]  TOUT_SHORT   = 16'h0200;
    localparam logic [15:0]  TOUT_LONG    = 16'h2000;
    localparam logic [15:0]  STARTUP_EXT  = 16'h0006;
    localparam logic [15:0]  STARTUP_258  = 16'h0102;
    localparam logic [15:0]  STARTUP_1K   = 16'h0400;
    localparam logic [15:0]  STARTUP_16K  = 16'h4000;
    localparam logic [15:0]  STARTUP_32K  = 16'h8000;
    localparam logic [15:0]  RESET_EXTRA  = 16'h000E;

    // System clock prescaler
    localparam logic [2:0]   DIV8_LAST    = 3'h7;

endpackage : clock_ctrl_pkg

// ### verilog/tick_counter.sv
// Loadable down-counter that counts qualified ticks to zero
`timescale 1ns/100ps
module tick_counter #(
    parameter int unsigned W = 16
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         tick,
    // Status
    output logic              done
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (load) begin
            cnt_nxt = load_val;
        end else if (tick && (cnt_r != '0)) begin
            cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign done = (cnt_r == '0);

endmodule : tick_counter

// ### verilog/clock_startup_ctrl.sv
// Clock source decode, reset start-up sequencing and clock domain gating
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module clock_startup_ctrl
    import clock_ctrl_pkg::*;
#(
    parameter logic [15:0] TOUT_LONG_CNT   = clock_ctrl_pkg::TOUT_LONG,
    parameter logic [15:0] STARTUP_16K_CNT = clock_ctrl_pkg::STARTUP_16K,
    parameter logic [15:0] STARTUP_32K_CNT = clock_ctrl_pkg::STARTUP_32K
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Pins from fuses, reset sources, oscillators and wake logic
    input  wire clock_ctrl_pkg::fuse_t fuse_pins,
    input  wire logic                  ext_reset_n,
    input  wire logic                  wdt_osc,
    input  wire logic                  src_osc,
    input  wire logic                  wake_req,
    // Clock system outputs
    output clock_ctrl_pkg::gate_t      domain_en,
    output logic                       internal_reset_n,
    output logic                       sys_tick,
    output clock_ctrl_pkg::src_t       source_sel
);
    import clock_ctrl_pkg::*;

    // Two-flop synchronisers for every pin input
    fuse_t        fuse_s1_r;
    fuse_t        fuse_s2_r;
    logic [3:0]   pin_s1_r;
    logic [3:0]   pin_s2_r;
    logic [1:0]   osc_d_r;
    logic         ext_rst_s;
    logic         wake_s;
    logic         wdt_tick;
    logic         osc_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_s1_r <= FUSE_DEFAULT;
            fuse_s2_r <= FUSE_DEFAULT;
            pin_s1_r  <= 4'h0;
            pin_s2_r  <= 4'h0;
            osc_d_r   <= 2'h0;
        end else begin
            fuse_s1_r <= fuse_pins;
            fuse_s2_r <= fuse_s1_r;
            pin_s1_r  <= {src_osc, wdt_osc, wake_req, ext_reset_n};
            pin_s2_r  <= pin_s1_r;
            osc_d_r   <= pin_s2_r[3:2];
        end
    end

    // Wake is sampled on pclk, which never stops, so it works with the peripheral clock halted
    assign ext_rst_s = pin_s2_r[0];
    assign wake_s    = pin_s2_r[1];
    assign wdt_tick  = pin_s2_r[2] & ~osc_d_r[0];
    assign osc_tick  = pin_s2_r[3] & ~osc_d_r[1];

    // State
    state_t      state_r;
    state_t      state_nxt;
    fuse_t       fuse_r;
    fuse_t       fuse_nxt;
    sleep_t      mode_r;
    sleep_t      mode_nxt;
    logic        asy_en_r;
    logic        asy_en_nxt;
    gate_t       gate_r;
    gate_t       gate_nxt;
    logic        irst_n_r;
    logic        irst_n_nxt;
    logic [2:0]  div_cnt_r;
    logic [2:0]  div_cnt_nxt;
    logic        tick_r;
    logic        tick_nxt;
    src_t        src_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pready_r;
    logic        pslverr_r;
    logic        pslverr_nxt;

    // Fuse decode
    src_t        src_dec;
    logic [15:0] tout_len;
    logic [15:0] su_len;
    logic [15:0] su_load_val;
    logic [2:0]  xtal_idx;
    logic        tout_load;
    logic        su_load;
    logic        tout_done;
    logic        su_done;
    logic        deep_sleep;
    logic        wr_en;
    logic        rd_setup;
    logic        addr_ok;

    always_comb begin
        xtal_idx = {fuse_r.clock_source_select[0], fuse_r.startup_time_select};
        src_dec  = SRC_RSV;
        if (fuse_r.clock_source_select[3]) begin
            src_dec = SRC_LP_XTAL;
        end else if (fuse_r.clock_source_select[2:1] == GRP_FS_XTAL) begin
            src_dec = SRC_FS_XTAL;
        end else if (fuse_r.clock_source_select[2:1] == GRP_LF_XTAL) begin
            src_dec = SRC_LF_XTAL;
        end else if (fuse_r.clock_source_select == CODE_RC_128K) begin
            src_dec = SRC_RC_128K;
        end else if (fuse_r.clock_source_select == CODE_RC_CAL) begin
            src_dec = SRC_RC_CAL;
        end else if (fuse_r.clock_source_select == CODE_EXT) begin
            src_dec = SRC_EXT;
        end
        // Non-crystal sources: time-out from start-up select, short fixed start-up
        unique case (fuse_r.startup_time_select)
            2'b00:   tout_len = CNT_ZERO;
            2'b01:   tout_len = TOUT_SHORT;
            2'b10:   tout_len = TOUT_LONG_CNT;
            2'b11:   tout_len = TOUT_LONG_CNT;
        endcase
        su_len = STARTUP_EXT;
        if (src_dec == SRC_LF_XTAL) begin
            su_len = STARTUP_32K_CNT;
        end else if ((src_dec == SRC_LP_XTAL) || (src_dec == SRC_FS_XTAL)) begin
            unique case (xtal_idx)
                3'd0:    begin su_len = STARTUP_258;     tout_len = TOUT_SHORT;    end
                3'd1:    begin su_len = STARTUP_258;     tout_len = TOUT_LONG_CNT; end
                3'd2:    begin su_len = STARTUP_1K;      tout_len = CNT_ZERO;      end
                3'd3:    begin su_len = STARTUP_1K;      tout_len = TOUT_SHORT;    end
                3'd4:    begin su_len = STARTUP_1K;      tout_len = TOUT_LONG_CNT; end
                3'd5:    begin su_len = STARTUP_16K_CNT; tout_len = CNT_ZERO;      end
                3'd6:    begin su_len = STARTUP_16K_CNT; tout_len = TOUT_SHORT;    end
                3'd7:    begin su_len = STARTUP_16K_CNT; tout_len = TOUT_LONG_CNT; end
            endcase
        end
    end

    // Time-out runs on watchdog ticks, start-up on selected oscillator ticks
    tick_counter #(.W(CNT_W)) tout_cnt (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (tout_load),
        .load_val (tout_len),
        .tick     (wdt_tick),
        .done     (tout_done)
    );

    tick_counter #(.W(CNT_W)) su_cnt (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (su_load),
        .load_val (su_load_val),
        .tick     (osc_tick),
        .done     (su_done)
    );

    // APB decode; zero wait states, so read data are taken in the setup cycle
    assign wr_en    = psel & penable & pwrite & pready_r;
    assign rd_setup = psel & ~penable;
    assign addr_ok  = (paddr == CTRL_OFS) || (paddr == STATUS_OFS) ||
                      (paddr == FUSE_OFS) || (paddr == DOMAIN_OFS);

    // Sequencer
    always_comb begin
        state_nxt   = state_r;
        fuse_nxt    = fuse_r;
        tout_load   = 1'b0;
        su_load     = 1'b0;
        su_load_val = su_len + RESET_EXTRA;
        deep_sleep  = (mode_r == SLP_PWR_DOWN) || (mode_r == SLP_PWR_SAVE);
        unique case (state_r)
            ST_HOLD: begin
                fuse_nxt = fuse_s2_r;
                if (ext_rst_s) begin
                    state_nxt = ST_DECODE;
                end
            end
            ST_DECODE: begin
                tout_load = 1'b1;
                state_nxt = ST_TIMEOUT;
            end
            ST_TIMEOUT: begin
                if (tout_done) begin
                    su_load   = 1'b1;
                    state_nxt = ST_STARTUP;
                end
            end
            ST_STARTUP: begin
                if (su_done) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (wr_en && (paddr == CTRL_OFS) && pwdata[CTRL_SLEEP_BIT]) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_s && deep_sleep) begin
                    su_load     = 1'b1;
                    su_load_val = su_len;
                    state_nxt   = ST_WAKE;
                end else if (wake_s) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_WAKE: begin
                if (su_done) begin
                    state_nxt = ST_RUN;
                end
            end
            default: state_nxt = ST_HOLD;
        endcase
        if (!ext_rst_s) begin
            state_nxt = ST_HOLD;
        end
    end

    // Domain gating follows the next state so the enables line up with state_r
    always_comb begin
        irst_n_nxt  = (state_nxt == ST_RUN) || (state_nxt == ST_SLEEP) ||
                      (state_nxt == ST_WAKE);
        mode_nxt    = mode_r;
        asy_en_nxt  = asy_en_r;
        if (wr_en && (paddr == CTRL_OFS) && (state_r != ST_SLEEP)) begin
            mode_nxt   = sleep_t'(pwdata[CTRL_MODE_MSB:CTRL_MODE_LSB]);
            asy_en_nxt = pwdata[CTRL_ASY_BIT];
        end
        gate_nxt = '0;
        if (state_nxt == ST_RUN) begin
            gate_nxt.core_clock       = 1'b1;
            gate_nxt.peripheral_clock = 1'b1;
            gate_nxt.converter_clock  = 1'b1;
            gate_nxt.async_timer_clock = asy_en_nxt;
        end else if (state_nxt == ST_SLEEP) begin
            unique case (mode_nxt)
                SLP_IDLE: begin
                    gate_nxt.peripheral_clock = 1'b1;
                    gate_nxt.converter_clock  = 1'b1;
                    gate_nxt.async_timer_clock = asy_en_nxt;
                end
                SLP_ADC_NR: begin
                    gate_nxt.converter_clock  = 1'b1;
                    gate_nxt.async_timer_clock = asy_en_nxt;
                end
                SLP_PWR_SAVE: gate_nxt.async_timer_clock = asy_en_nxt;
                SLP_PWR_DOWN: gate_nxt.async_timer_clock = 1'b0;
            endcase
        end else if (state_nxt == ST_WAKE) begin
            gate_nxt.async_timer_clock = asy_en_nxt && (mode_nxt == SLP_PWR_SAVE);
        end
        gate_nxt.flash_clock = gate_nxt.core_clock;
        // Programmed divide fuse gives one system tick in eight
        div_cnt_nxt = div_cnt_r + 3'h1;
        if (fuse_r.divide_by_eight_fuse == FUSE_PROGRAMMED) begin
            tick_nxt = (div_cnt_r == DIV8_LAST);
        end else begin
            tick_nxt = 1'b1;
        end
    end

    // Register read mux
    always_comb begin
        prdata_nxt  = prdata_r;
        pslverr_nxt = pslverr_r;
        if (rd_setup) begin
            pslverr_nxt = ~addr_ok;
            prdata_nxt  = 32'h0000_0000;
            if (paddr == CTRL_OFS) begin
                prdata_nxt[CTRL_MODE_MSB:CTRL_MODE_LSB] = mode_r;
                prdata_nxt[CTRL_ASY_BIT]                = asy_en_r;
            end else if (paddr == STATUS_OFS) begin
                prdata_nxt[STAT_SRC_LSB +: 3]   = src_r;
                prdata_nxt[STAT_STATE_LSB +: 3] = state_r;
                prdata_nxt[STAT_RUN_BIT]        = irst_n_r;
            end else if (paddr == FUSE_OFS) begin
                prdata_nxt[FUSE_W-1:0] = fuse_r;
            end else if (paddr == DOMAIN_OFS) begin
                prdata_nxt[4:0] = gate_r;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= ST_HOLD;
            fuse_r    <= FUSE_DEFAULT;
            mode_r    <= SLP_IDLE;
            asy_en_r  <= 1'b0;
            gate_r    <= '0;
            irst_n_r  <= 1'b0;
            div_cnt_r <= 3'h0;
            tick_r    <= 1'b0;
            src_r     <= SRC_RC_CAL;
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            fuse_r    <= fuse_nxt;
            mode_r    <= mode_nxt;
            asy_en_r  <= asy_en_nxt;
            gate_r    <= gate_nxt;
            irst_n_r  <= irst_n_nxt;
            div_cnt_r <= div_cnt_nxt;
            tick_r    <= tick_nxt;
            src_r     <= src_dec;
            prdata_r  <= prdata_nxt;
            pready_r  <= 1'b1;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata           = prdata_r;
    assign pready           = pready_r;
    assign pslverr          = pslverr_r;
    assign domain_en        = gate_r;
    assign internal_reset_n = irst_n_r;
    assign sys_tick         = tick_r;
    assign source_sel       = src_r;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence timeout_end_s;
        (state_r == ST_TIMEOUT) && tout_done && ext_rst_s;
    endsequence

    sequence startup_end_s;
        (state_r == ST_STARTUP) && su_done && ext_rst_s;
    endsequence

    lp_xtal_decode_a: assert property (fuse_r.clock_source_select[3] |-> ##1
        src_r == SRC_LP_XTAL)
        else $error("upper source codes not decoded as low-power crystal");
    rc_decode_a: assert property ((fuse_r.clock_source_select == CODE_RC_128K)
        |-> ##1 src_r == SRC_RC_128K)
        else $error("code 0011 not decoded as 128 kHz RC");
    div8_spacing_a: assert property ((tick_r && !$past(fuse_r.divide_by_eight_fuse))
        |-> $past(div_cnt_r) == DIV8_LAST)
        else $error("divided system tick off its slot");
    reset_hold_a: assert property (!ext_rst_s |=> !irst_n_r ##1 !irst_n_r)
        else $error("internal reset released while reset source active");
    timeout_step_a: assert property (timeout_end_s |=>
        (state_r == ST_STARTUP) && !irst_n_r)
        else $error("time-out end did not start the start-up count");
    startup_release_a: assert property (startup_end_s |=>
        irst_n_r && gate_r.core_clock)
        else $error("start-up end did not release reset");
    wake_no_tout_a: assert property (((state_r == ST_SLEEP) && wake_s && deep_sleep
        && ext_rst_s) |=> state_r == ST_WAKE)
        else $error("deep-sleep wake took the wrong path");
    core_gate_a: assert property (!irst_n_r |-> !gate_r.core_clock &&
        (gate_r.flash_clock == gate_r.core_clock))
        else $error("core or flash clock on while held in reset");
    adc_quiet_a: assert property (((state_r == ST_SLEEP) && (mode_r == SLP_ADC_NR))
        |-> gate_r.converter_clock && !gate_r.peripheral_clock)
        else $error("converter noise mode gating wrong");
    save_async_a: assert property ((state_r == ST_SLEEP) &&
        (mode_r == SLP_PWR_SAVE) |-> gate_r.async_timer_clock == asy_en_r)
        else $error("async timer clock lost in power-save");
    fuse_hold_a: assert property ((state_r != ST_HOLD) &&
        ($past(state_r) != ST_HOLD) |-> $stable(fuse_r))
        else $error("fuse image changed during operation");

endmodule : clock_startup_ctrl

// ### sim/testbench.sv
// Self-checking bench for the clock source and start-up controller
`timescale 1ns/100ps
module testbench;
    import clock_ctrl_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        ext_reset_n = 0, wdt_osc = 0, src_osc = 0, wake_req = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic        pready, pslverr, internal_reset_n, sys_tick, e;
    logic [6:0]  r;
    logic [1:0]  ph = '0;
    fuse_t       fuse_pins = FUSE_DEFAULT;
    gate_t       domain_en;
    src_t        source_sel;
    int          miscompares = 0, n_checks = 0, cyc = 0, n, k;
    // Shortened long counts keep the run short
    clock_startup_ctrl #(.TOUT_LONG_CNT(16'h0010), .STARTUP_16K_CNT(16'h0014),
        .STARTUP_32K_CNT(16'h0018)) u_clock_startup_ctrl (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fuse_pins,
        .ext_reset_n, .wdt_osc, .src_osc, .wake_req, .domain_en, .internal_reset_n,
        .sys_tick, .source_sel);
    always #25 pclk = ~pclk;
    // Both oscillators run at a quarter of pclk, two cycles high and two low
    always @(posedge pclk) begin
        ph <= ph + 2'h1;
        wdt_osc <= ph[1];
        src_osc <= ph[1];
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            miscompares++;
            test_done;
        end
    end
    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        k = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    function src_t dec(logic [3:0] c);
        if (c[3]) return SRC_LP_XTAL;
        if (c[3:1] == 3'h3) return SRC_FS_XTAL;
        if (c[3:1] == 3'h2) return SRC_LF_XTAL;
        return src_t'(c[2:0]);
    endfunction : dec
    // Total ticks from reset: time-out, then start-up plus the fixed reset extra
    function int ticks(fuse_t f);
        logic [2:0] i;
        i = {f.clock_source_select[0], f.startup_time_select};
        if (dec(f.clock_source_select) inside {SRC_LP_XTAL, SRC_FS_XTAL})
            return (i % 3 == 0 ? 512 : i % 3 == 1 ? 16 : 0)
                + (i < 2 ? 258 : i < 5 ? 1024 : 20) + 14;
        return (f.startup_time_select == 0 ? 0 : f.startup_time_select == 1 ? 512 : 16)
            + (dec(f.clock_source_select) == SRC_LF_XTAL ? 24 : 6) + 14;
    endfunction : ticks
    task boot(input fuse_t f);
        @(posedge pclk);
        ext_reset_n <= 1'h0;
        fuse_pins <= f;
        repeat (6) @(posedge pclk);
        ext_reset_n <= 1'h1;
        n = 0;
        while (internal_reset_n !== 1'h1 && n < 9000) begin
            @(posedge pclk);
            n++;
        end
        k = ticks(f);
        chk("release_min", 32'(n >= 4 * k - 4), 1);
        chk("release_max", 32'(n <= 4 * k + 32), 1);
        chk("source", 32'(source_sel), 32'(dec(f.clock_source_select)));
        chk("domains", 32'(domain_en), 32'h1D);
        k = 0;
        repeat (16) begin
            @(posedge pclk);
            k += sys_tick;
        end
        chk("sys_tick", k, f.divide_by_eight_fuse ? 16 : 2);
        $display("boot test %h done", f);
    endtask : boot
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    initial begin
        void'($urandom(32));
        repeat (6) @(posedge pclk);
        chk("reset", {pready, internal_reset_n, 1'h0, source_sel}, 32'h2);
        presetn <= 1'h1;
        boot(7'h7F);
        boot(7'h01);
        boot(7'h09);
        for (int j = 0; j < 8; j++) begin
            r = $urandom;
            boot(r);
        end
        boot(FUSE_DEFAULT);
        apb(1'h0, STATUS_OFS, 32'h0);
        chk("status", q, 32'h142);
        fuse_pins <= 7'h00;
        repeat (5) @(posedge pclk);
        apb(1'h0, FUSE_OFS, 32'h0);
        chk("fuse", q, 32'(FUSE_DEFAULT));
        chk("held", 32'(source_sel), 32'(SRC_RC_CAL));
        apb(1'h0, 12'h010, 32'h0);
        chk("slverr", 32'(e), 1);
        $display("register test done");
        // Gate enables per mode: idle, converter noise, power-down, power-save
        for (int m = 0; m < 4; m++) begin
            apb(1'h1, CTRL_OFS, 32'({m == 3, 2'(m), 1'h1}));
            repeat (3) @(posedge pclk);
            chk("sleep", 32'(domain_en),
                m == 0 ? 32'h09 : m == 1 ? 32'h01 : m == 2 ? 32'h00 : 32'h02);
            wake_req <= 1'h1;
            repeat (3) @(posedge pclk);
            n = 3;
            while (domain_en.core_clock !== 1'h1 && n < 200) begin
                @(posedge pclk);
                n++;
            end
            wake_req <= 1'h0;
            chk("wake", 32'(n <= (m < 2 ? 8 : 48)), 1);
            chk("stay", 32'(internal_reset_n), 1);
            repeat (4) @(posedge pclk);
            $display("sleep mode %0d test done", m);
        end
        test_done;
    end
endmodule : testbench
